// ---- aon_regs.vh ----
`ifndef AON_REGS_VH
`define AON_REGS_VH
// register indices; byte address is four times the index
`define AON_OVS_IDX       6'h07
`define AON_NODE_IDX      6'h0a
`define AON_CTRL_IDX      6'h10
`define AON_STAT_IDX      6'h11
// oversampling control fields
`define AON_ORDER_BIT     7
`define AON_HPER_MSB      6
`define AON_HPER_LSB      5
`define AON_GPER_MSB      4
`define AON_GPER_LSB      3
`define AON_CNT_MSB       2
`define AON_CNT_LSB       0
// node address and control fields
`define AON_NODE_MSB      4
`define AON_CTRL_SEL_BIT  0
`define AON_CTRL_TRIG_BIT 1
// reset values
`define AON_OVS_RESET     8'h78
`define AON_NODE_RESET    5'h00
// channel numbering: cells, aux, then internal test signals
`define AON_NONE          5'h1f
`define AON_CELL_HI       5'h0f
`define AON_AUX_LO        5'h10
`define AON_AUX_HI        5'h17
`define AON_TST_LO        5'h18
`define AON_ANA_HI        5'h1b
`define AON_DTEMP_CH      5'h1c
`define AON_TST_HI        5'h1d
// bus responses
`define AON_RESP_OKAY     2'h0
`define AON_RESP_SLVERR   2'h2
// timing, in ns
`define AON_CLK_NS        8
`define AON_PER0_NS       4130
`define AON_PER1_NS       5960
`define AON_PER2_NS       8020
`define AON_PER3_NS       12600
`endif

// ---- aon_period.v ----
`include "aon_regs.vh"
`default_nettype none
module aon_period
(
  // period code and its length in clock cycles
  input  wire [1:0]  code,
  output reg  [15:0] cycles
);
  // least times, so round up to whole cycles
  localparam [15:0] CYC0 = (`AON_PER0_NS + `AON_CLK_NS - 1) / `AON_CLK_NS;
  localparam [15:0] CYC1 = (`AON_PER1_NS + `AON_CLK_NS - 1) / `AON_CLK_NS;
  localparam [15:0] CYC2 = (`AON_PER2_NS + `AON_CLK_NS - 1) / `AON_CLK_NS;
  localparam [15:0] CYC3 = (`AON_PER3_NS + `AON_CLK_NS - 1) / `AON_CLK_NS;

  always @*
  begin
    case (code)
      2'h0: cycles = CYC0;
      2'h1: cycles = CYC1;
      2'h2: cycles = CYC2;
      default: cycles = CYC3;
    endcase
  end
endmodule
`default_nettype wire

// ---- aon_round.v ----
`default_nettype none
module aon_round #(
  parameter IN_W  = 21,
  parameter OUT_W = 16
)
(
  // accumulated sum and log2 of the sample count
  input  wire [IN_W-1:0]  sum,
  input  wire [2:0]       shift,
  output reg  [OUT_W-1:0] avg
);
  reg [IN_W:0] q;
  reg [IN_W:0] rem;
  reg [IN_W:0] half;

  // round half to even, saturate to the output width
  always @*
  begin
    q    = {1'b0, sum} >> shift;
    rem  = {1'b0, sum} & ((({{IN_W{1'b0}}, 1'b1}) << shift) - 1'b1);
    half = ({{IN_W{1'b0}}, 1'b1} << shift) >> 1;
    if (shift != 3'h0 && (rem > half || (rem == half && q[0])))
      q = q + 1'b1;
    if (q[IN_W:OUT_W] != {(IN_W-OUT_W+1){1'b0}})
      avg = {OUT_W{1'b1}};
    else
      avg = q[OUT_W-1:0];
  end
endmodule
`default_nettype wire

// ---- aon_ctrl.v ----
// Notes on behaviour
// - with the order bit clear, all repeats of a channel run first, a cell or aux channel's first after its settle time, the rest at the averaging period.
// - with the order bit set, one sample per selected channel per sweep, sweeps repeat up to the sample count.
// - in round-robin, cell averages finish before aux sampling, and aux finishes before any other measurement.
// - in round-robin, the cell settle time precedes cell sampling and the aux settle time precedes aux sampling.
// - the order bit affects only cell and aux averaging, never the internal test measurements.
// - the analog period times die temperature, reference, pump and stack-sum, and cell repeats in per-channel mode.
// - the digital period times digital die temperature and core supply, and digital die temperature is never averaged.
// - in per-channel mode the digital period times aux repeats.
// - digital period codes 0..3 mean 4.13, 5.96, 8.02 and 12.6 us.
// - sample count codes 0..5 average 1, 2, 4, 8, 16, 32 samples; 6 and 7 are reserved.
// - the averaged sum is reduced to 16 bits with round-half-to-even before it is stored.
// - the node identifier takes writes only while address capture is armed.
// - the node identifier may also load from nonvolatile storage or from sampled pins.
// - with source select 1 the trigger arms capture until the next frame; with 0 it samples the pins.
`include "aon_regs.vh"
`default_nettype none
module aon_ctrl #(
  parameter ADDR_W   = 8,
  parameter SAMPLE_W = 16,
  parameter ACC_W    = 21,
  parameter NUM_CH   = 30
)
(
  // clock and reset
  input  wire                aclk,
  input  wire                aresetn,
  // axi4-lite write
  input  wire [ADDR_W-1:0]   awaddr,
  input  wire                awvalid,
  output reg                 awready,
  input  wire [31:0]         wdata,
  input  wire [3:0]          wstrb,
  input  wire                wvalid,
  output reg                 wready,
  output reg  [1:0]          bresp,
  output reg                 bvalid,
  input  wire                bready,
  // axi4-lite read
  input  wire [ADDR_W-1:0]   araddr,
  input  wire                arvalid,
  output reg                 arready,
  output reg  [31:0]         rdata,
  output reg  [1:0]          rresp,
  output reg                 rvalid,
  input  wire                rready,
  // conversion command and converter
  input  wire                conv_start,
  input  wire [NUM_CH-1:0]   chan_sel,
  input  wire [15:0]         cell_settle_period,
  input  wire [15:0]         aux_settle_period,
  output reg                 sample_req,
  output reg  [4:0]          sample_chan,
  input  wire                sample_done,
  input  wire [SAMPLE_W-1:0] sample_data,
  output reg                 result_valid,
  output reg  [4:0]          result_chan,
  output reg  [15:0]         result_data,
  output reg                 conv_busy,
  // node addressing
  input  wire                frame_received,
  input  wire [4:0]          gpio_addr,
  input  wire                nvm_load,
  input  wire [4:0]          nvm_addr,
  output reg  [4:0]          node_identifier,
  output reg                 auto_addr_mode
);
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_LOAD = 4'h2;
  localparam [3:0] S_WAIT = 4'h4;
  localparam [3:0] S_SMP  = 4'h8;

  reg  [7:0]        ovs_reg;
  reg               addr_sel_reg;
  reg  [ADDR_W-1:0] awaddr_reg;
  reg  [31:0]       wdata_reg;
  reg               wstrb0_reg;
  reg  [3:0]        state_reg;
  reg  [5:0]        pass_reg;
  reg  [15:0]       wait_reg;
  reg  [NUM_CH-1:0] sel_reg;
  reg               run_order_reg;
  reg  [1:0]        run_hper_reg;
  reg  [1:0]        run_gper_reg;
  reg  [2:0]        run_cnt_reg;
  reg  [ACC_W-1:0]  acc [0:NUM_CH-1];
  wire [15:0]       hcyc;
  wire [15:0]       gcyc;
  wire [15:0]       avg;
  wire [ADDR_W-3:0] wr_idx = awaddr_reg[ADDR_W-1:2];
  wire [ADDR_W-3:0] rd_idx = araddr[ADDR_W-1:2];
  wire              do_write = ~awready & ~wready & ~bvalid;

  aon_period u_hper
  (
    .code   (run_hper_reg),
    .cycles (hcyc)
  );

  aon_period u_gper
  (
    .code   (run_gper_reg),
    .cycles (gcyc)
  );

  // smallest selected channel in [lo, hi], or none
  function [4:0] next_sel;
    input [NUM_CH-1:0] m;
    input [4:0]        lo;
    input [4:0]        hi;
    integer            i;
    begin
      next_sel = `AON_NONE;
      for (i = NUM_CH - 1; i >= 0; i = i - 1)
        if (m[i] && i >= lo && i <= hi)
          next_sel = i[4:0];
    end
  endfunction

  // wait before a sample; first means first sample of a channel in per-channel order, or of a sweep phase
  function [15:0] per_of;
    input [4:0] ch;
    input       first;
    begin
      if (ch <= `AON_CELL_HI)
        per_of = first ? cell_settle_period : hcyc;
      else if (ch <= `AON_AUX_HI)
        per_of = first ? aux_settle_period : gcyc;
      else if (ch <= `AON_ANA_HI)
        per_of = hcyc;
      else
        per_of = gcyc;
    end
  endfunction

  // die temperature is a single sample
  // reserved count codes fall back to one sample
  wire [2:0] shift = (sample_chan == `AON_DTEMP_CH || run_cnt_reg > 3'h5) ? 3'h0 : run_cnt_reg;
  wire [5:0] count = 6'h01 << shift;
  wire       last  = (pass_reg + 6'h01) == count;
  // test channels always sequence per channel
  wire       rr    = run_order_reg && sample_chan <= `AON_AUX_HI;
  wire [4:0] ph_lo = (sample_chan <= `AON_CELL_HI) ? 5'h00 : `AON_AUX_LO;
  wire [4:0] ph_hi = (sample_chan <= `AON_CELL_HI) ? `AON_CELL_HI : `AON_AUX_HI;
  wire [4:0] nxt_any = next_sel(sel_reg, sample_chan + 5'h01, `AON_TST_HI);
  wire [4:0] nxt_ph  = next_sel(sel_reg, sample_chan + 5'h01, ph_hi);
  wire [4:0] first_ph = next_sel(sel_reg, ph_lo, ph_hi);
  wire [4:0] nxt_late = next_sel(sel_reg, ph_hi + 5'h01, `AON_TST_HI);
  wire [ACC_W-1:0] new_sum = (pass_reg == 6'h00 ? {ACC_W{1'b0}} : acc[sample_chan])
                             + {{(ACC_W-SAMPLE_W){1'b0}}, sample_data};

  aon_round #(
    .IN_W  (ACC_W),
    .OUT_W (16)
  ) u_round
  (
    .sum   (new_sum),
    .shift (shift),
    .avg   (avg)
  );

  // write channel: address and data taken in either order, response after both
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      bvalid     <= 1'b0;
      bresp      <= `AON_RESP_OKAY;
      awaddr_reg <= {ADDR_W{1'b0}};
      wdata_reg  <= 32'h0;
      wstrb0_reg <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready    <= 1'b0;
        awaddr_reg <= awaddr;
      end
      if (wvalid && wready)
      begin
        wready     <= 1'b0;
        wdata_reg  <= wdata;
        wstrb0_reg <= wstrb[0];
      end
      if (do_write)
      begin
        bvalid <= 1'b1;
        if (wr_idx == `AON_OVS_IDX || wr_idx == `AON_NODE_IDX || wr_idx == `AON_CTRL_IDX
            || wr_idx == `AON_STAT_IDX)
          bresp <= `AON_RESP_OKAY;
        else
          bresp <= `AON_RESP_SLVERR;
      end
      else if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // register writes; the live copy changes any time, the sequencer uses its frozen copy
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ovs_reg      <= `AON_OVS_RESET;
      addr_sel_reg <= 1'b0;
    end
    else if (do_write && wstrb0_reg)
    begin
      if (wr_idx == `AON_OVS_IDX)
        ovs_reg <= wdata_reg[7:0];
      else if (wr_idx == `AON_CTRL_IDX)
        addr_sel_reg <= wdata_reg[`AON_CTRL_SEL_BIT];
    end
  end

  // node identifier and capture arming; a fresh arm wins over a frame clearing it
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      node_identifier <= `AON_NODE_RESET;
      auto_addr_mode  <= 1'b0;
    end
    else
    begin
      if (frame_received)
        auto_addr_mode <= 1'b0;
      if (nvm_load)
        node_identifier <= nvm_addr;
      if (do_write && wstrb0_reg)
      begin
        if (wr_idx == `AON_NODE_IDX && auto_addr_mode)
          node_identifier <= wdata_reg[`AON_NODE_MSB:0];
        else if (wr_idx == `AON_CTRL_IDX && wdata_reg[`AON_CTRL_TRIG_BIT])
        begin
          if (wdata_reg[`AON_CTRL_SEL_BIT])
            auto_addr_mode <= 1'b1;
          else
            node_identifier <= gpio_addr;
        end
      end
    end
  end

  // read channel; one outstanding read, answer one cycle after the address
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `AON_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= `AON_RESP_OKAY;
      if (rd_idx == `AON_OVS_IDX)
        rdata <= {24'h0, ovs_reg};
      else if (rd_idx == `AON_NODE_IDX)
        rdata <= {27'h0, node_identifier};
      else if (rd_idx == `AON_CTRL_IDX)
        rdata <= {30'h0, auto_addr_mode, addr_sel_reg};
      else if (rd_idx == `AON_STAT_IDX)
        rdata <= {25'h0, sample_chan, auto_addr_mode, conv_busy};
      else
      begin
        rdata <= 32'h0;
        rresp <= `AON_RESP_SLVERR;
      end
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // conversion sequencer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg     <= S_IDLE;
      sample_chan   <= 5'h00;
      pass_reg      <= 6'h00;
      wait_reg      <= 16'h0;
      sel_reg       <= {NUM_CH{1'b0}};
      run_order_reg <= 1'b0;
      run_hper_reg  <= 2'h3;
      run_gper_reg  <= 2'h3;
      run_cnt_reg   <= 3'h0;
      sample_req    <= 1'b0;
      result_valid  <= 1'b0;
      result_chan   <= 5'h00;
      result_data   <= 16'h0;
      conv_busy     <= 1'b0;
    end
    else
    begin
      sample_req   <= 1'b0;
      result_valid <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          if (conv_start)
          begin
            sel_reg       <= chan_sel;
            run_order_reg <= ovs_reg[`AON_ORDER_BIT];
            run_hper_reg  <= ovs_reg[`AON_HPER_MSB:`AON_HPER_LSB];
            run_gper_reg  <= ovs_reg[`AON_GPER_MSB:`AON_GPER_LSB];
            run_cnt_reg   <= ovs_reg[`AON_CNT_MSB:`AON_CNT_LSB];
            conv_busy     <= 1'b1;
            state_reg     <= S_LOAD;
          end
        end
        S_LOAD:
        begin
          pass_reg <= 6'h00;
          if (next_sel(sel_reg, 5'h00, `AON_TST_HI) == `AON_NONE)
          begin
            conv_busy <= 1'b0;
            state_reg <= S_IDLE;
          end
          else
          begin
            sample_chan <= next_sel(sel_reg, 5'h00, `AON_TST_HI);
            wait_reg    <= per_of(next_sel(sel_reg, 5'h00, `AON_TST_HI), 1'b1);
            state_reg   <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          if (wait_reg <= 16'h0001)
          begin
            sample_req <= 1'b1;
            state_reg  <= S_SMP;
          end
          else
            wait_reg <= wait_reg - 16'h0001;
        end
        S_SMP:
        begin
          if (sample_done)
          begin
            acc[sample_chan] <= new_sum;
            if (last)
            begin
              result_valid <= 1'b1;
              result_chan  <= sample_chan;
              result_data  <= avg;
            end
            state_reg <= S_WAIT;
            if (!rr && !last)
            begin
              // repeat same channel at averaging period
              pass_reg <= pass_reg + 6'h01;
              wait_reg <= per_of(sample_chan, 1'b0);
            end
            else if (!rr)
            begin
              pass_reg <= 6'h00;
              if (nxt_any == `AON_NONE)
              begin
                conv_busy <= 1'b0;
                state_reg <= S_IDLE;
              end
              else
              begin
                sample_chan <= nxt_any;
                wait_reg    <= per_of(nxt_any, 1'b1);
              end
            end
            else if (nxt_ph != `AON_NONE)
            begin
              sample_chan <= nxt_ph;
              wait_reg    <= per_of(nxt_ph, 1'b0);
            end
            else if (!last)
            begin
              pass_reg    <= pass_reg + 6'h01;
              sample_chan <= first_ph;
              wait_reg    <= per_of(first_ph, 1'b0);
            end
            else
            begin
              // phase done before the next phase
              pass_reg <= 6'h00;
              if (nxt_late == `AON_NONE)
              begin
                conv_busy <= 1'b0;
                state_reg <= S_IDLE;
              end
              else
              begin
                sample_chan <= nxt_late;
                wait_reg    <= per_of(nxt_late, 1'b1);
              end
            end
          end
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- aon_ctrl_sva.sv ----
`default_nettype none
module aon_ctrl_sva
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  // converter side
  input wire logic        conv_start,
  input wire logic        conv_busy,
  input wire logic        sample_req,
  input wire logic [4:0]  sample_chan,
  input wire logic        sample_done,
  input wire logic        result_valid,
  // addressing
  input wire logic        frame_received,
  input wire logic        nvm_load,
  input wire logic [4:0]  node_identifier,
  input wire logic        auto_addr_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // a response must stay put until the master takes it
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  // the write executes one cycle after both halves are taken, so the response shows a cycle later
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  a_req_pulse: assert property (sample_req |=> !sample_req)
    else $error("sample request longer than one cycle");
  a_chan_hold: assert property (sample_req |=> $stable(sample_chan))
    else $error("sample channel moved under a request");
  a_busy_start: assert property (conv_start && !conv_busy |=> conv_busy)
    else $error("conversion did not start");
  a_result_cause: assert property (result_valid |-> $past(sample_done))
    else $error("result without a finished sample");
  // an arming write in flight may win over the frame, so only judge when no write is pending
  a_frame_clear: assert property (auto_addr_mode && frame_received && awready |=> !auto_addr_mode)
    else $error("capture not disarmed by frame");
  a_node_source: assert property ($changed(node_identifier) |-> $rose(bvalid) || $past(nvm_load))
    else $error("node identifier changed without cause");
endmodule
bind aon_ctrl aon_ctrl_sva u_sva (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .conv_start, .conv_busy, .sample_req, .sample_chan,
  .sample_done, .result_valid, .frame_received, .nvm_load, .node_identifier, .auto_addr_mode);
`default_nettype wire

// ---- adc_oversample_and_node_address_bench.sv ----
`default_nettype none
module adc_oversample_and_node_address_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready;
  logic        rvalid, conv_start, sample_req, sample_done, result_valid, conv_busy, frame_received;
  logic        nvm_load, auto_addr_mode;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [29:0] chan_sel;
  logic [15:0] cell_settle_period, aux_settle_period, sample_data, result_data, d;
  logic [4:0]  sample_chan, result_chan, gpio_addr, nvm_addr, node_identifier;
  int          miscompares, total_checks, cyc, kk, res_n, n, last_ch, last_done, gap_on, gp;
  int          pns[4] = '{4130, 5960, 8020, 12600};
  int          sums[32], cnt[32], seen[$], ex[$];

  aon_ctrl dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .conv_start, .chan_sel,
    .cell_settle_period, .aux_settle_period, .sample_req, .sample_chan, .sample_done, .sample_data,
    .result_valid, .result_chan, .result_data, .conv_busy, .frame_received, .gpio_addr, .nvm_load,
    .nvm_addr, .node_identifier, .auto_addr_mode);

  always #4 aclk = ~aclk;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // average of 2^k samples, round half to even, saturated
  function automatic logic [15:0] rnd(input int s, input int k);
    int q;
    int rm;
    q = s >> k;
    rm = s - (q << k);
    if (k > 0 && (rm > (1 << (k - 1)) || (rm == (1 << (k - 1)) && q % 2 == 1)))
      q++;
    return (q > 65535) ? 16'hffff : 16'(q);
  endfunction

  // address and data are offered together; either may be taken first
  task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
    bit ao;
    bit wo;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    ao = 0;
    wo = 0;
    while (!(ao && wo))
    begin
      @(posedge aclk);
      if (!ao && awready === 1'b1)
      begin
        ao = 1;
        awvalid <= 0;
      end
      if (!wo && wready === 1'b1)
      begin
        wo = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk("rresp", er, rresp);
    if (er == 0)
      chk("rdata", e, rdata);
    rready <= 0;
  endtask

  // settings rewritten mid-command must not touch the running one
  task automatic conv(input logic [29:0] m, input logic [7:0] o, input int k);
    wr(8'h1c, {24'h0, o}, r);
    kk = k;
    gp = o[4:3];
    last_ch = 99;
    seen = {};
    res_n = 0;
    chan_sel <= m;
    conv_start <= 1;
    @(posedge aclk);
    conv_start <= 0;
    wr(8'h1c, 32'h67, r);
    do @(posedge aclk); while (conv_busy !== 1'b0);
    // the last result is booked at this same edge by another process
    @(posedge aclk);
  endtask

  // converter stand-in, gap and sum bookkeeping
  always @(posedge aclk)
    if (sample_req === 1'b1)
    begin
      d = 16'($urandom);
      seen.push_back(sample_chan);
      sums[sample_chan] += d;
      cnt[sample_chan]++;
      if (gap_on && sample_chan == last_ch)
        chk("gap", 1, cyc - last_done >= (pns[gp] + 7) / 8 - 1 && cyc - last_done <= (pns[gp] + 7) / 8 + 4);
      last_ch = sample_chan;
      sample_data <= d;
      sample_done <= 1;
      @(posedge aclk);
      sample_done <= 0;
      last_done = cyc;
    end

  // reference averaging model, compared at every result
  always @(posedge aclk)
    if (result_valid === 1'b1)
    begin
      n = (result_chan == 5'h1c || kk > 5) ? 1 : 1 << kk;
      chk("sample count", n, cnt[result_chan]);
      chk("average", rnd(sums[result_chan], n == 1 ? 0 : kk), result_data);
      sums[result_chan] = 0;
      cnt[result_chan] = 0;
      res_n++;
    end

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      miscompares++;
      finish_test;
    end
  end

  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, conv_start, sample_done} = 0;
    {frame_received, nvm_load, awaddr, araddr, wdata, chan_sel, sample_data} = 0;
    {gpio_addr, nvm_addr, cell_settle_period, aux_settle_period} = 0;
    wstrb = 4'hf;
    void'($urandom(32'h70d7127b));
    last_ch = 99;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    cell_settle_period <= 16'(20 + $urandom % 40);
    aux_settle_period <= 16'(20 + $urandom % 40);
    rd(8'h1c, 32'h78, 2'h0);
    rd(8'h28, 32'h0, 2'h0);
    rd(8'h2c, 32'h0, 2'h2);
    wr(8'h2c, 32'h1, r);
    chk("bresp", 2'h2, r);
    wr(8'h28, 32'h15, r);
    rd(8'h28, 32'h0, 2'h0);
    wr(8'h40, 32'h3, r);
    chk("armed", 1, auto_addr_mode);
    rd(8'h40, 32'h3, 2'h0);
    rd(8'h44, 32'h2, 2'h0);
    wr(8'h28, 32'h15, r);
    chk("node", 5'h15, node_identifier);
    @(posedge aclk);
    frame_received <= 1;
    @(posedge aclk);
    frame_received <= 0;
    @(posedge aclk);
    chk("armed", 0, auto_addr_mode);
    wr(8'h28, 32'h09, r);
    rd(8'h28, 32'h15, 2'h0);
    gpio_addr <= 5'h0b;
    wr(8'h40, 32'h2, r);
    chk("node", 5'h0b, node_identifier);
    nvm_addr <= 5'h1e;
    nvm_load <= 1;
    @(posedge aclk);
    nvm_load <= 0;
    @(posedge aclk);
    chk("node", 5'h1e, node_identifier);
    gap_on = 1;
    for (int k = 0; k < 8; k++)
    begin
      conv(30'h1 << 16, 8'h60 | (8'(k % 4) << 3) | 8'(k), k);
      chk("results", 1, res_n);
    end
    gap_on = 0;
    ex = {0, 0, 1, 1, 16, 16, 24, 24, 28};
    for (int o = 0; o < 2; o++)
    begin
      conv(30'h11010003, o ? 8'he1 : 8'h61, 1);
      chk("results", 5, res_n);
      chk("samples", 9, seen.size());
      if (o)
        ex = {0, 1, 0, 1, 16, 16, 24, 24, 28};
      foreach (ex[i])
        chk("sample order", ex[i], seen[i]);
    end
    rd(8'h44, 32'h70, 2'h0);
    finish_test;
  end
endmodule
`default_nettype wire
